/* File: design/icbl_pkg.sv */
// Constants, state types and helpers for the two-wire bus condition logic.
// Assumes one 100 MHz clock and a synchronous active-high reset.
// ----------------------------------------------------------------------
// Overview of operation
// RULE1: In an enabled two-wire mode both pins are open-drain: pull low or release.
// RULE2: Software sets both pin direction bits as inputs before using the mode.
// RULE3: Pin output data is forced to zero while the mode is enabled.
// RULE4: Hold-select bit set keeps SDA valid 300 ns after SCL falls.
// RULE5: SDA falling while SCL high is a Start; bus goes idle to active.
// RULE6: Only a master generates a Start; a slave never does.
// RULE7: Generating a Start, SDA already low before our pull is a collision.
// RULE8: SDA rising while SCL high is a Stop.
// RULE9: Stop counts only after one SCL low period since the Start.
// RULE10: Repeated Start is accepted exactly where a Stop would be.
// RULE11: Repeated Start resets slave logic like a Start, awaiting an address.
// RULE12: 10-bit read needs prior match, restart, high byte; slave then holds SCL.
// RULE13: Prior-match set on full 10-bit write match; cleared by Stop or high byte.
// RULE14: SDA sampled low while we release it expecting high is a collision.
// RULE15: Matched read address: slave sends every byte until restart or Stop.
// RULE16: Bus idle only when no master holds it and both lines high.
// RULE17: An address byte matches when equal to the slave address register; in 7-bit mode the code compares bits 7:1 only, ignoring the read/write bit.
// RULE18: Anyone may hold SCL low; others wait for its release.
// RULE19: The master starts each transfer, drives all clocks and ends it.
// RULE20: Transmitter releases SDA after the eighth SCL fall, reads the acknowledge.
// RULE21: SDA changes only while SCL low and is sampled on SCL rising.
// RULE22: Both bus inputs are synchronised; edges found from previous and current.
// ----------------------------------------------------------------------
package icbl_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int HOLD_LONG_NS   = 300;
   localparam int HOLD_SHORT_NS  = 100;
   localparam int START_SETUP_NS = 600;
   localparam int CNT_W          = 7;
   localparam logic [CNT_W-1:0] HOLD_LONG_CNT =
      CNT_W'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLD_SHORT_CNT =
      CNT_W'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] START_CNT =
      CNT_W'((START_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;

   // ----------------------------------------------------------------------
   // Addressing
   // ----------------------------------------------------------------------
   localparam logic [4:0] TEN_HI_PREFIX = 5'h1e;
   localparam int         RW_BIT        = 0;
   localparam int         A9_BIT        = 2;
   localparam int         A8_BIT        = 1;

   // Start generator states
   typedef enum logic [1:0] {
      GEN_IDLE,
      GEN_CHECK,
      GEN_SDA,
      GEN_HAND
   } icbl_gen_t;

   typedef struct packed {
      logic             scl_q;
      logic             sda_q;
      logic             active;
      logic             low_seen;
      logic             prior;
      logic             hi_ok;
      logic             slave_tx;
      logic             scl_hold;
      logic             coll_flag;
      logic             start_p;
      logic             stop_p;
      logic             restart_p;
      logic             match_p;
      logic             done_p;
      logic             gen_sda;
      icbl_gen_t        gen;
      logic [CNT_W-1:0] cnt;
   } icbl_state_t;

   // Compare the seven address bits above the read/write bit
   function automatic logic icbl_addr_eq(input logic [7:0] rx,
                                         input logic [6:0] ref_bits);
      return rx[7:1] == ref_bits;
   endfunction : icbl_addr_eq

endpackage : icbl_pkg

/* File: design/icbl_sync.sv */
// Two-flop synchroniser for the bus pin inputs.
// Assumes inputs arrive asynchronously to clk_i.
module icbl_sync
   import icbl_pkg::*;
#(
   parameter int W = 2
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } icbl_sync_t;

   icbl_sync_t st_r;
   icbl_sync_t st_nxt;

   // Idle bus reads high, so reset to ones avoids a false edge
   always_comb begin
      st_nxt.meta   = d_i;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_o = st_r.stable;

endmodule : icbl_sync

/* File: design/icbl_sda_hold.sv */
// SDA drive stage that holds the line still after each SCL fall.
// Assumes scl_fall_i is a one-cycle pulse on the synchronised SCL.
module icbl_sda_hold
   import icbl_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic scl_fall_i,
   input  wire logic long_i,
   input  wire logic req_i,
   output logic      drive_o
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             drive;
   } icbl_hold_t;

   icbl_hold_t st_r;
   icbl_hold_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (scl_fall_i) begin
         st_nxt.cnt = long_i ? HOLD_LONG_CNT : HOLD_SHORT_CNT; // [RULE4]
      end else if (st_r.cnt != CNT_ZERO) begin
         st_nxt.cnt = st_r.cnt - 7'h01;
      end else begin
         st_nxt.drive = req_i; // [RULE20]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign drive_o = st_r.drive;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   hold_load_a: assert property ( // [RULE4]
      scl_fall_i && long_i |=> st_r.cnt == HOLD_LONG_CNT)
      else $error("long hold count not loaded");

   hold_still_a: assert property ( // [RULE4]
      st_r.cnt != CNT_ZERO |=> $stable(drive_o))
      else $error("SDA drive changed inside hold window");

endmodule : icbl_sda_hold

/* File: design/icbl_bus_cond.sv */
// Bus condition front end of the two-wire serial port.
// Assumes the byte sequencer runs on clk_i and talks through the request,
// address and status ports; the bus pins are asynchronous.
module icbl_bus_cond
   import icbl_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       serial_port_enable_bit_i,
   input  wire logic       data_hold_select_bit_i,
   input  wire logic       ten_bit_mode_i,
   input  wire logic       master_mode_i,
   input  wire logic [7:0] slave_address_register_i,
   input  wire logic       gen_start_i,
   input  wire logic       scl_low_req_i,
   input  wire logic       sda_low_req_i,
   input  wire logic       tx_active_i,
   input  wire logic       release_clock_i,
   input  wire logic       collision_clear_i,
   input  wire logic [7:0] addr_byte_i,
   input  wire logic       addr_first_i,
   input  wire logic       addr_second_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   output logic            sda_o,
   output logic            sda_oe_o,
   output logic            start_o,
   output logic            stop_o,
   output logic            restart_o,
   output logic            slave_reset_o,
   output logic            start_done_o,
   output logic            bus_idle_o,
   output logic            bus_collision_o,
   output logic            addr_match_o,
   output logic            prior_match_o,
   output logic            slave_transmit_o
);
   icbl_state_t st_r;
   icbl_state_t st_nxt;
   logic        port_rst;
   logic [1:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        sda_drive;
   logic        scl_high;
   logic        sda_fall;
   logic        sda_rise;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        restart_c;
   logic        stop_c;
   logic        coll_drive;
   logic        coll_start;
   logic        idle_c;
   logic        hi_match;
   logic        rx_rw;

   // Disabling the port holds everything in reset
   assign port_rst = rst_i | ~serial_port_enable_bit_i;

   // ----------------------------------------------------------------------
   // Pin sampling and edge detection
   // ----------------------------------------------------------------------
   icbl_sync #(
      .W (2)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (port_rst),
      .d_i   ({scl_i, sda_i}),
      .q_o   (pins_s)
   ); // [RULE22]

   assign scl_s    = pins_s[1];
   assign sda_s    = pins_s[0];
   assign scl_high = scl_s & st_r.scl_q;
   assign sda_fall = st_r.sda_q & ~sda_s;                // [RULE22]
   assign sda_rise = ~st_r.sda_q & sda_s;
   assign scl_rise = scl_s & ~st_r.scl_q;
   assign scl_fall = ~scl_s & st_r.scl_q;

   assign start_c   = sda_fall & scl_high & ~st_r.active;         // [RULE5]
   assign restart_c = sda_fall & scl_high & st_r.active
                      & st_r.low_seen;                            // [RULE10]
   assign stop_c    = sda_rise & scl_high & st_r.active
                      & st_r.low_seen;                     // [RULE8] [RULE9]
   assign idle_c    = ~st_r.active & scl_s & sda_s;               // [RULE16]

   // Released line read low on the SCL rise means another driver [RULE21]
   assign coll_drive = tx_active_i & ~sda_drive & scl_rise & ~sda_s; // [RULE14]
   assign coll_start = (st_r.gen == GEN_CHECK) & ~sda_s;             // [RULE7]

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   assign rx_rw    = addr_byte_i[RW_BIT];
   assign hi_match = ten_bit_mode_i
      ? icbl_addr_eq(addr_byte_i, {TEN_HI_PREFIX,
                     slave_address_register_i[A9_BIT],
                     slave_address_register_i[A8_BIT]})
      : icbl_addr_eq(addr_byte_i, slave_address_register_i[7:1]); // [RULE17]

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt           = st_r;
      st_nxt.scl_q     = scl_s;
      st_nxt.sda_q     = sda_s;
      st_nxt.start_p   = start_c;
      st_nxt.restart_p = restart_c;
      st_nxt.stop_p    = stop_c;
      st_nxt.match_p   = 1'b0;
      st_nxt.done_p    = 1'b0;

      // Bus activity tracking
      if (st_r.active && !scl_s) begin
         st_nxt.low_seen = 1'b1;                                  // [RULE9]
      end
      if (start_c || restart_c) begin
         st_nxt.active   = 1'b1;                                  // [RULE5]
         st_nxt.low_seen = 1'b0;
         st_nxt.slave_tx = 1'b0;                                  // [RULE11]
         st_nxt.hi_ok    = 1'b0;
         st_nxt.scl_hold = 1'b0;
      end
      if (stop_c) begin
         st_nxt.active   = 1'b0;
         st_nxt.low_seen = 1'b0;
         st_nxt.slave_tx = 1'b0;                                  // [RULE15]
         st_nxt.hi_ok    = 1'b0;
         st_nxt.scl_hold = 1'b0;
         st_nxt.prior    = 1'b0;                                  // [RULE13]
      end

      // Address bytes, delivered by the sequencer after a start
      if (addr_first_i) begin
         if (ten_bit_mode_i) begin
            if (!hi_match) begin
               st_nxt.prior = 1'b0;                               // [RULE13]
               st_nxt.hi_ok = 1'b0;
            end else if (!rx_rw) begin
               st_nxt.prior   = 1'b0;                             // [RULE13]
               st_nxt.hi_ok   = 1'b1;
               st_nxt.match_p = 1'b1;
            end else if (st_r.prior) begin
               st_nxt.slave_tx = 1'b1;                            // [RULE12]
               st_nxt.scl_hold = 1'b1;
               st_nxt.match_p  = 1'b1;
            end
         end else if (hi_match) begin
            st_nxt.match_p  = 1'b1;                               // [RULE17]
            st_nxt.slave_tx = rx_rw;                              // [RULE15]
         end
      end
      if (addr_second_i && ten_bit_mode_i && st_r.hi_ok) begin
         st_nxt.hi_ok = 1'b0;
         if (addr_byte_i == slave_address_register_i) begin
            st_nxt.prior   = 1'b1;                                // [RULE13]
            st_nxt.match_p = 1'b1;
         end
      end
      // Clock stretch after a 10-bit read match until the sequencer is ready
      if (release_clock_i) begin
         st_nxt.scl_hold = 1'b0;                                  // [RULE18]
      end

      // Start generator, master only
      case (st_r.gen)
         GEN_IDLE: begin
            if (gen_start_i && master_mode_i && idle_c) begin     // [RULE6]
               st_nxt.gen = GEN_CHECK;
            end
         end
         GEN_CHECK: begin
            if (!sda_s) begin
               st_nxt.gen = GEN_IDLE;                             // [RULE7]
            end else begin
               st_nxt.gen     = GEN_SDA;
               st_nxt.gen_sda = 1'b1;
               st_nxt.cnt     = START_CNT;
            end
         end
         GEN_SDA: begin
            if (st_r.cnt == CNT_ZERO) begin
               st_nxt.gen = GEN_HAND;
            end else begin
               st_nxt.cnt = st_r.cnt - 7'h01;
            end
         end
         GEN_HAND: begin
            // Keep SDA low until the sequencer owns SCL, avoiding a Stop
            if (scl_low_req_i) begin
               st_nxt.gen     = GEN_IDLE;                         // [RULE19]
               st_nxt.gen_sda = 1'b0;
               st_nxt.done_p  = 1'b1;
            end
         end
         default: begin
            st_nxt.gen     = GEN_IDLE;
            st_nxt.gen_sda = 1'b0;
         end
      endcase

      // Sticky collision; a new event wins over a clear
      if (collision_clear_i) begin
         st_nxt.coll_flag = 1'b0;
      end
      if (coll_drive || coll_start) begin
         st_nxt.coll_flag = 1'b1;                         // [RULE7] [RULE14]
      end
   end

   always_ff @(posedge clk_i) begin
      if (port_rst) begin
         st_r       <= '0;
         st_r.scl_q <= 1'b1;
         st_r.sda_q <= 1'b1;
         st_r.gen   <= GEN_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------------
   icbl_sda_hold u_hold (
      .clk_i      (clk_i),
      .rst_i      (port_rst),
      .scl_fall_i (scl_fall),
      .long_i     (data_hold_select_bit_i),
      .req_i      (sda_low_req_i | st_r.gen_sda),
      .drive_o    (sda_drive)
   ); // [RULE4]

   assign scl_o    = 1'b0;                                        // [RULE3]
   assign sda_o    = 1'b0;                                        // [RULE3]
   assign scl_oe_o = serial_port_enable_bit_i
                     & (scl_low_req_i | st_r.scl_hold);           // [RULE1]
   assign sda_oe_o = serial_port_enable_bit_i & sda_drive;        // [RULE1]

   assign start_o          = st_r.start_p;
   assign stop_o           = st_r.stop_p;
   assign restart_o        = st_r.restart_p;
   assign slave_reset_o    = st_r.start_p | st_r.restart_p;       // [RULE11]
   assign start_done_o     = st_r.done_p;
   assign bus_idle_o       = ~st_r.active & st_r.scl_q & st_r.sda_q;
   assign bus_collision_o  = st_r.coll_flag;
   assign addr_match_o     = st_r.match_p;
   assign prior_match_o    = st_r.prior;
   assign slave_transmit_o = st_r.slave_tx;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (port_rst);

   sequence sda_fell_scl_high;
      sda_fall && scl_high;
   endsequence

   start_seen_a: assert property ( // [RULE5]
      sda_fell_scl_high ##0 !st_r.active |=> start_o ##1 st_r.active)
      else $error("Start not reported");

   stop_gate_a: assert property ( // [RULE9]
      sda_rise && scl_high && !st_r.low_seen |=> !stop_o)
      else $error("Stop accepted without SCL low period");

   restart_gate_a: assert property ( // [RULE10]
      sda_fell_scl_high ##0 st_r.active && st_r.low_seen
      |=> restart_o && slave_reset_o)
      else $error("Restart not reported");

   pins_off_a: assert property ( // [RULE1]
      disable iff (rst_i)
      !serial_port_enable_bit_i |-> !scl_oe_o && !sda_oe_o)
      else $error("pin driven while port disabled");

   start_coll_a: assert property ( // [RULE7]
      st_r.gen == GEN_CHECK && !sda_s
      |=> bus_collision_o && st_r.gen == GEN_IDLE && !st_r.gen_sda)
      else $error("Start collision missed");

   drive_coll_a: assert property ( // [RULE14]
      coll_drive |=> bus_collision_o
      ##1 (bus_collision_o || $past(collision_clear_i)))
      else $error("drive collision not held");

   prior_clear_a: assert property ( // [RULE13]
      stop_c |=> !prior_match_o && !slave_transmit_o)
      else $error("Stop did not clear prior match");

   ten_read_a: assert property ( // [RULE12]
      addr_first_i && ten_bit_mode_i && hi_match && rx_rw && st_r.prior
      && !release_clock_i && !stop_c && !start_c && !restart_c
      |=> slave_transmit_o && scl_oe_o)
      else $error("10-bit read did not hold SCL");

   idle_level_a: assert property ( // [RULE16]
      bus_idle_o |-> !$past(st_r.active) || $past(stop_c))
      else $error("idle reported while active");

endmodule : icbl_bus_cond

/* File: test/icbl_bus_master.sv */
// Behavioural two-wire bus master standing on the far side of the block.
// Assumes the testbench resolves the open-drain wires with pull-ups.
module icbl_bus_master (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_pull_o,
   output logic      sda_pull_o
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF_NS = 80;

   // Lines released and clock still outside frames
   initial begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
   end

   task automatic half();
      #(HALF_NS);
   endtask : half

   task automatic drive(input logic scl_lo, input logic sda_lo);
      scl_pull_o = scl_lo;
      sda_pull_o = sda_lo;
   endtask : drive

   // Release SCL; a stretching party may keep it low, so wait, bounded
   task automatic rise();
      scl_pull_o = 1'b0;
      for (int i = 0; i < 200 && scl_i !== 1'b1; i++) #10;
      half();
   endtask : rise

   task automatic start();
      sda_pull_o = 1'b1;
      half();
      scl_pull_o = 1'b1;
      half();
   endtask : start

   task automatic send_bit(input logic b);
      sda_pull_o = ~b;
      half();
      rise();
      scl_pull_o = 1'b1;
      half();
   endtask : send_bit

   task automatic stop();
      sda_pull_o = 1'b1;
      half();
      rise();
      sda_pull_o = 1'b0;
      half();
   endtask : stop

   task automatic restart();
      sda_pull_o = 1'b0;
      half();
      rise();
      sda_pull_o = 1'b1;
      half();
      scl_pull_o = 1'b1;
      half();
   endtask : restart
endmodule : icbl_bus_master

/* File: test/tb_icbl_bus_cond.sv */
// Self-checking bench for the bus condition front end.
// Assumes the behavioural master model and open-drain wires with pull-ups.
module tb_icbl_bus_cond;
   timeunit 1ns;
   timeprecision 100ps;
   import icbl_pkg::*;

   logic clk_i = 1'b0, rst_i = 1'b1, en = 1'b0, hold_sel = 1'b0;
   logic ten = 1'b0, mstr = 1'b0, gen = 1'b0, scl_req = 1'b0;
   logic sda_req = 1'b0, tx_act = 1'b0, rel_clk = 1'b0, coll_clr = 1'b0;
   logic a_first = 1'b0, a_second = 1'b0;
   logic [7:0] sar = 8'h00, abyte = 8'h00;
   logic scl_o, scl_oe, sda_o, sda_oe, start_p, stop_p, restart_p;
   logic slv_rst, done_p, idle, coll, match_p, prior, slv_tx;
   logic scl_pull, sda_pull;
   wire  logic scl_w = ~(scl_pull | scl_oe);
   wire  logic sda_w = ~(sda_pull | sda_oe);
   int miscompares = 0, samples_checked = 0;
   int n_start, n_stop, n_rst, n_restart, n_match, n_done;

   always #5 clk_i = ~clk_i;

   icbl_bus_cond dut (.clk_i(clk_i), .rst_i(rst_i),
      .serial_port_enable_bit_i(en), .data_hold_select_bit_i(hold_sel),
      .ten_bit_mode_i(ten), .master_mode_i(mstr),
      .slave_address_register_i(sar), .gen_start_i(gen),
      .scl_low_req_i(scl_req), .sda_low_req_i(sda_req),
      .tx_active_i(tx_act), .release_clock_i(rel_clk),
      .collision_clear_i(coll_clr), .addr_byte_i(abyte),
      .addr_first_i(a_first), .addr_second_i(a_second),
      .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .start_o(start_p),
      .stop_o(stop_p), .restart_o(restart_p), .slave_reset_o(slv_rst),
      .start_done_o(done_p), .bus_idle_o(idle), .bus_collision_o(coll),
      .addr_match_o(match_p), .prior_match_o(prior),
      .slave_transmit_o(slv_tx));

   icbl_bus_master mst (.scl_i(scl_w), .sda_i(sda_w),
      .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

   // ----------------------------------------------------------------------
   // Pulse counters and checks
   // ----------------------------------------------------------------------
   always @(posedge clk_i) begin
      n_start   += (start_p === 1'b1);
      n_stop    += (stop_p === 1'b1);
      n_rst     += (slv_rst === 1'b1);
      n_restart += (restart_p === 1'b1);
      n_match   += (match_p === 1'b1);
      n_done    += (done_p === 1'b1);
   end

   always @(negedge clk_i) begin
      if (en === 1'b1 && (scl_o !== 1'b0 || sda_o !== 1'b0)) begin
         miscompares++;
         $display("mismatch at %0t: pin data not zero", $time);
      end
   end

   task automatic chk(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %b", $time, what, got);
      end
   endtask : chk

   task automatic chk_n(input int got, input int exp, input string what);
      samples_checked++;
      if (got != exp) begin
         miscompares++;
         $display("mismatch at %0t: %s count %0d", $time, what, got);
      end
   endtask : chk_n

   task automatic clr();
      {n_start, n_stop, n_rst, n_restart, n_match, n_done} = '0;
   endtask : clr

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc

   task automatic addr(input logic [7:0] b, input logic first);
      @(negedge clk_i);
      abyte = b;
      a_first = first;
      a_second = ~first;
      @(negedge clk_i);
      a_first = 1'b0;
      a_second = 1'b0;
      cyc(2);
   endtask : addr

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic sc_start_stop();
      clr();
      mst.start();
      chk_n(n_start, 1, "start");
      chk(idle, 1'b0, "idle while active");
      mst.send_bit(1'b1);
      mst.stop();
      cyc(6);
      chk_n(n_stop, 1, "stop");
      chk(idle, 1'b1, "idle after stop");
      clr();
      mst.drive(1'b0, 1'b1);
      mst.half();
      mst.drive(1'b0, 1'b0);
      mst.half();
      cyc(6);
      chk_n(n_start, 1, "start without low");
      chk_n(n_stop, 0, "stop without low");
      mst.start();
      mst.stop();
      cyc(6);
   endtask : sc_start_stop

   task automatic sc_restart();
      mst.start();
      mst.send_bit(1'b0);
      clr();
      mst.restart();
      chk_n(n_restart, 1, "restart");
      chk_n(n_rst, 1, "slave reset");
      chk_n(n_stop, 0, "stop on restart");
      sar = 8'h42;
      addr(8'h43, 1'b1);
      chk_n(n_match, 1, "7-bit match");
      chk(slv_tx, 1'b1, "read request");
      addr(8'h44, 1'b1);
      chk_n(n_match, 1, "7-bit miss");
      mst.stop();
      cyc(6);
      chk(slv_tx, 1'b0, "transmit after stop");
   endtask : sc_restart

   task automatic sc_ten_bit();
      ten = 1'b1;
      sar = 8'h06;
      mst.start();
      mst.send_bit(1'b0);
      clr();
      addr(8'hf7, 1'b1);
      chk_n(n_match, 0, "read without prior");
      addr(8'hf6, 1'b1);
      addr(8'h06, 1'b0);
      chk(prior, 1'b1, "prior set");
      mst.restart();
      chk(prior, 1'b1, "prior kept on restart");
      addr(8'hf7, 1'b1);
      chk_n(n_match, 3, "ten-bit matches");
      chk(slv_tx, 1'b1, "ten-bit transmit");
      mst.drive(1'b0, 1'b0);
      cyc(8);
      chk(scl_w, 1'b0, "scl held by slave");
      @(negedge clk_i);
      rel_clk = 1'b1;
      @(negedge clk_i);
      rel_clk = 1'b0;
      cyc(2);
      chk(scl_oe, 1'b0, "scl released");
      mst.drive(1'b1, 1'b0);
      mst.stop();
      cyc(6);
      chk(prior, 1'b0, "prior after stop");
      ten = 1'b0;
   endtask : sc_ten_bit

   task automatic sc_hold();
      mst.start();
      for (int l = 1; l >= 0; l--) begin
         hold_sel = l[0];
         sda_req = 1'b1;
         cyc(6);
         mst.drive(1'b0, 1'b0);
         mst.half();
         mst.drive(1'b1, 1'b0);
         cyc(5);
         sda_req = 1'b0;
         #150;
         chk(sda_oe, l[0], "sda held after scl fall");
         #200;
         chk(sda_oe, 1'b0, "sda released");
      end
      mst.stop();
      cyc(6);
   endtask : sc_hold

   task automatic sc_collision();
      mst.start();
      tx_act = 1'b1;
      mst.send_bit(1'b0);
      chk(coll, 1'b1, "drive collision");
      @(negedge clk_i);
      coll_clr = 1'b1;
      @(negedge clk_i);
      coll_clr = 1'b0;
      tx_act = 1'b0;
      cyc(2);
      chk(coll, 1'b0, "collision cleared");
      mst.send_bit(1'b0);
      chk(coll, 1'b0, "no collision while idle tx");
      mst.stop();
      cyc(6);
   endtask : sc_collision

   task automatic sc_gen_start();
      gen = 1'b1;
      cyc(8);
      chk(sda_oe, 1'b0, "slave start refused");
      // SDA taken low one cycle before the request reaches the check
      mst.drive(1'b0, 1'b1);
      cyc(1);
      mstr = 1'b1;
      cyc(1);
      gen = 1'b0;
      cyc(3);
      chk(coll, 1'b1, "start collision");
      chk(sda_oe, 1'b0, "start aborted");
      mst.drive(1'b1, 1'b1);
      mst.half();
      mst.stop();
      cyc(6);
      coll_clr = 1'b1;
      @(negedge clk_i);
      coll_clr = 1'b0;
      clr();
      mstr = 1'b1;
      @(negedge clk_i);
      gen = 1'b1;
      @(negedge clk_i);
      gen = 1'b0;
      cyc(6);
      chk(sda_oe, 1'b1, "generated sda pull");
      chk(coll, 1'b0, "no start collision");
      sda_req = 1'b1;
      cyc(70);
      chk_n(n_start, 1, "generated start seen");
      scl_req = 1'b1;
      cyc(3);
      chk(scl_oe, 1'b1, "scl pulled");
      chk_n(n_done, 1, "start handed over");
      scl_req = 1'b0;
      cyc(10);
      sda_req = 1'b0;
      cyc(10);
      chk_n(n_stop, 1, "own stop");
      scl_req = 1'b1;
      en = 1'b0;
      cyc(2);
      chk(scl_oe, 1'b0, "disabled port releases");
      scl_req = 1'b0;
      mstr = 1'b0;
   endtask : sc_gen_start

   task automatic close_out();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   // Pin direction bits left as inputs: only oe pulls the wires
   initial begin
      cyc(4);
      rst_i = 1'b0;
      en = 1'b1;
      cyc(6);
      sc_start_stop();
      sc_restart();
      sc_ten_bit();
      sc_hold();
      sc_collision();
      sc_gen_start();
      close_out();
   end

   initial begin
      #500000;
      miscompares++;
      close_out();
   end
endmodule : tb_icbl_bus_cond
